/* File: design/iox_pkg.sv */
// package for the i2c octal io expander
// Functional notes
// - start is sda falling while scl high
// - ack matching address on ninth clock
// - sda change during scl high is control
// - stop is sda rising, return idle
// - one ack bit after each byte
// - ack every received byte as receiver
// - on master nack release sda
// - address is 11100 plus two selects
// - last address bit one means read
// - first written byte is register pointer
// - pointer persists across transfers
// - input register reads pins, ignores writes
// - output register drives outputs, resets ff
// - polarity bits invert input reads, reset 00
// - direction one input, zero output, reset ff
// - write data bytes load selected register
// - read after restart sends selected register
// - read returns any number of bytes
// - capture pins at ack scl rise
// - input pin change raises active-low alert
// - alert clears on restore or input read
// - reset pin restores all defaults
`default_nettype none
package iox_pkg;
  localparam logic [4:0] IOX_ADDR_FIXED = 5'h1c;
  localparam logic [1:0] IOX_REG_INPUT = 2'h0;
  localparam logic [1:0] IOX_REG_OUTPUT = 2'h1;
  localparam logic [1:0] IOX_REG_INVERT = 2'h2;
  localparam logic [1:0] IOX_REG_DIR = 2'h3;
  localparam logic [7:0] IOX_RST_OUTPUT = 8'hff;
  localparam logic [7:0] IOX_RST_INVERT = 8'h00;
  localparam logic [7:0] IOX_RST_DIR = 8'hff;
  localparam logic [3:0] IOX_BIT_LAST = 4'h7;
  localparam logic [3:0] IOX_BIT_ACK = 4'h8;

  typedef enum logic [2:0] {
    IOX_IDLE,
    IOX_RX,
    IOX_RX_ACK,
    IOX_TX,
    IOX_TX_ACK
  } iox_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } iox_bus_t;
endpackage : iox_pkg
`default_nettype wire

/* File: design/iox_sync3.sv */
// three-stage synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module iox_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic [WIDTH-1:0] D_IN,
  output logic [WIDTH-1:0] Q_OUT
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } iox_sync_st_t;

  iox_sync_st_t st_reg;
  iox_sync_st_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = D_IN;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.q[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      st_reg <= {4{INIT}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign Q_OUT = st_reg.q;
endmodule // iox_sync3
`default_nettype wire

/* File: design/iox_expander.sv */
// i2c slave octal io expander top
`timescale 1ns/100ps
`default_nettype none
module iox_expander
  import iox_pkg::*;
#(
  parameter int PINS = 8
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic RESET_N_PIN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  input wire logic ADDR_SELECT_HI,
  input wire logic ADDR_SELECT_LO,
  input wire logic [PINS-1:0] PORT_PIN_IN,
  output logic [PINS-1:0] PORT_PIN_OUT,
  output logic [PINS-1:0] PORT_PIN_OE_N,
  output logic ALERT_N_OUT,
  output logic ALERT_N_OE_N
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [PINS+4:0] raw_in;
  logic [PINS+4:0] syn_in;
  assign raw_in = {PORT_PIN_IN, RESET_N_PIN, ADDR_SELECT_HI, ADDR_SELECT_LO, SCL_IN, SDA_IN};

  iox_sync3 #(.WIDTH(PINS + 5), .INIT('1)) u_sync (
    .CLK_SYS(CLK_SYS),
    .RESET(RESET),
    .D_IN(raw_in),
    .Q_OUT(syn_in)
  );

  iox_bus_t bus;
  logic [PINS-1:0] pins;
  logic rst_pin_n;
  logic [1:0] sel;
  assign bus.scl = syn_in[1];
  assign bus.sda = syn_in[0];
  assign sel = syn_in[3:2];
  assign rst_pin_n = syn_in[4];
  assign pins = syn_in[PINS+4:5];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    iox_state_t fsm;
    iox_bus_t prev;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic is_addr;
    logic is_cmd;
    logic rd_ack;
    logic sda_low;
    logic [1:0] ptr;
    logic [PINS-1:0] drive_level_bits;
    logic [PINS-1:0] invert_bits;
    logic [PINS-1:0] direction_bits;
    logic [PINS-1:0] snap;
  } iox_st_t;

  iox_st_t st_reg;
  iox_st_t st_next;

  function automatic logic [7:0] reg_value(input iox_st_t s, input logic [PINS-1:0] p);
    unique case (s.ptr)
      IOX_REG_INPUT: reg_value = 8'(p ^ s.invert_bits);
      IOX_REG_OUTPUT: reg_value = 8'(s.drive_level_bits);
      IOX_REG_INVERT: reg_value = 8'(s.invert_bits);
      IOX_REG_DIR: reg_value = 8'(s.direction_bits);
    endcase
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  assign scl_rise = bus.scl & ~st_reg.prev.scl;
  assign scl_fall = ~bus.scl & st_reg.prev.scl;
  assign start_cond = bus.scl & st_reg.prev.scl & st_reg.prev.sda & ~bus.sda;
  assign stop_cond = bus.scl & st_reg.prev.scl & ~st_reg.prev.sda & bus.sda;

  // ---------------------------------------------------------------
  // protocol and register logic
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.prev = bus;
    if (start_cond) begin
      st_next.fsm = IOX_RX;
      st_next.bitcnt = '0;
      st_next.is_addr = 1'b1;
      st_next.sda_low = 1'b0;
    end else if (stop_cond) begin
      st_next.fsm = IOX_IDLE;
      st_next.sda_low = 1'b0;
    end else begin
      unique case (st_reg.fsm)
        IOX_IDLE: begin
          st_next.sda_low = 1'b0;
        end
        IOX_RX: begin
          if (scl_rise) begin
            st_next.shift = {st_reg.shift[6:0], bus.sda};
            st_next.bitcnt = st_reg.bitcnt + 4'h1;
          end
          if (scl_fall) begin
            if (st_reg.bitcnt == IOX_BIT_ACK) begin
              st_next.bitcnt = '0;
              if (st_reg.is_addr) begin
                if (st_reg.shift[7:1] == {IOX_ADDR_FIXED, sel}) begin
                  st_next.fsm = IOX_RX_ACK;
                  st_next.sda_low = 1'b1;
                  st_next.rd_ack = st_reg.shift[0];
                end else begin
                  st_next.fsm = IOX_IDLE;
                end
              end else begin
                st_next.fsm = IOX_RX_ACK;
                st_next.sda_low = 1'b1;
                st_next.rd_ack = 1'b0;
                if (st_reg.is_cmd) begin
                  st_next.ptr = st_reg.shift[1:0];
                  st_next.is_cmd = 1'b0;
                end else begin
                  unique case (st_reg.ptr)
                    IOX_REG_INPUT: ;
                    IOX_REG_OUTPUT: st_next.drive_level_bits = st_reg.shift[PINS-1:0];
                    IOX_REG_INVERT: st_next.invert_bits = st_reg.shift[PINS-1:0];
                    IOX_REG_DIR: st_next.direction_bits = st_reg.shift[PINS-1:0];
                  endcase
                end
              end
            end
          end
        end
        IOX_RX_ACK: begin
          if (scl_rise && st_reg.rd_ack) begin
            st_next.shift = reg_value(st_reg, pins);
            if (st_reg.ptr == IOX_REG_INPUT) begin
              st_next.snap = pins;
            end
          end
          if (scl_fall) begin
            if (st_reg.is_addr && !st_reg.rd_ack) begin
              st_next.is_cmd = 1'b1;
            end
            st_next.is_addr = 1'b0;
            if (st_reg.rd_ack) begin
              st_next.fsm = IOX_TX;
              st_next.sda_low = ~st_reg.shift[7];
            end else begin
              st_next.fsm = IOX_RX;
              st_next.sda_low = 1'b0;
            end
          end
        end
        IOX_TX: begin
          if (scl_fall) begin
            if (st_reg.bitcnt == IOX_BIT_LAST) begin
              st_next.bitcnt = '0;
              st_next.fsm = IOX_TX_ACK;
              st_next.sda_low = 1'b0;
            end else begin
              st_next.bitcnt = st_reg.bitcnt + 4'h1;
              st_next.shift = {st_reg.shift[6:0], 1'b1};
              st_next.sda_low = ~st_reg.shift[6];
            end
          end
        end
        IOX_TX_ACK: begin
          if (scl_rise) begin
            st_next.shift = reg_value(st_reg, pins);
            if (st_reg.ptr == IOX_REG_INPUT) begin
              st_next.snap = pins;
            end
            if (bus.sda) begin
              st_next.fsm = IOX_IDLE;
            end
          end
          if (scl_fall && st_reg.fsm == IOX_TX_ACK && !st_next.prev.sda) begin
            st_next.fsm = IOX_TX;
            st_next.sda_low = ~st_reg.shift[7];
          end
        end
      endcase
    end
    if (!rst_pin_n) begin
      st_next = '0;
      st_next.fsm = IOX_IDLE;
      st_next.prev = bus;
      st_next.drive_level_bits = IOX_RST_OUTPUT;
      st_next.invert_bits = IOX_RST_INVERT;
      st_next.direction_bits = IOX_RST_DIR;
      st_next.snap = pins;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      st_reg <= '0;
      st_reg.fsm <= IOX_IDLE;
      st_reg.prev <= '1;
      st_reg.drive_level_bits <= IOX_RST_OUTPUT;
      st_reg.invert_bits <= IOX_RST_INVERT;
      st_reg.direction_bits <= IOX_RST_DIR;
      st_reg.snap <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign SDA_OUT = 1'b0;
  assign SDA_OE_N = ~st_reg.sda_low;
  assign PORT_PIN_OUT = st_reg.drive_level_bits;
  assign PORT_PIN_OE_N = st_reg.direction_bits;
  assign ALERT_N_OUT = 1'b0;
  assign ALERT_N_OE_N = ~|((pins ^ st_reg.snap) & st_reg.direction_bits);
endmodule // iox_expander
`default_nettype wire

/* File: test/iox_expander_props.sv */
// port assertions for the i2c io expander
`timescale 1ns/100ps
`default_nettype none
module iox_expander_props #(
  parameter int PINS = 8
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic RESET_N_PIN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_N,
  input wire logic ADDR_SELECT_HI,
  input wire logic ADDR_SELECT_LO,
  input wire logic [PINS-1:0] PORT_PIN_IN,
  input wire logic [PINS-1:0] PORT_PIN_OUT,
  input wire logic [PINS-1:0] PORT_PIN_OE_N,
  input wire logic ALERT_N_OUT,
  input wire logic ALERT_N_OE_N
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  AST_SDA_OUT: assert property (SDA_OUT == 1'b0) else $error("sda data level not low");
  AST_ALERT_OUT: assert property (ALERT_N_OUT == 1'b0) else $error("alert level not low");
  AST_STOP_IDLE: assert property ($rose(SDA_IN) && SCL_IN |-> ##1 SDA_OE_N [*8])
    else $error("sda pulled after stop");
  AST_ACK_HOLD: assert property ($fell(SDA_OE_N) |-> !SDA_OE_N [*8]) else $error("ack too short");
  AST_SDA_SCL_LOW: assert property ($changed(SDA_OE_N) && RESET_N_PIN && $past(RESET_N_PIN, 6) |-> !SCL_IN)
    else $error("sda changed while scl high");
  AST_DIR_SCL_LOW: assert property ($changed(PORT_PIN_OE_N) && RESET_N_PIN && $past(RESET_N_PIN, 6) |-> !SCL_IN)
    else $error("direction changed while scl high");
  AST_OUT_SCL_LOW: assert property ($changed(PORT_PIN_OUT) && RESET_N_PIN && $past(RESET_N_PIN, 6) |-> !SCL_IN)
    else $error("output changed while scl high");
  AST_RST_PIN: assert property (!RESET_N_PIN [*6] |-> PORT_PIN_OE_N == '1 && PORT_PIN_OUT == '1 && SDA_OE_N)
    else $error("reset pin defaults wrong");
  AST_RST_VAL: assert property ($fell(RESET) |-> PORT_PIN_OE_N == '1 && PORT_PIN_OUT == '1 && SDA_OE_N)
    else $error("reset defaults wrong");
endmodule // iox_expander_props
bind iox_expander iox_expander_props #(.PINS(PINS)) u_props (.CLK_SYS(CLK_SYS), .RESET(RESET),
  .RESET_N_PIN(RESET_N_PIN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
  .ADDR_SELECT_HI(ADDR_SELECT_HI), .ADDR_SELECT_LO(ADDR_SELECT_LO), .PORT_PIN_IN(PORT_PIN_IN),
  .PORT_PIN_OUT(PORT_PIN_OUT), .PORT_PIN_OE_N(PORT_PIN_OE_N), .ALERT_N_OUT(ALERT_N_OUT),
  .ALERT_N_OE_N(ALERT_N_OE_N));
`default_nettype wire

/* File: test/iox_master.sv */
// bit-banged i2c bus master model
`timescale 1ns/100ps
`default_nettype none
module iox_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // link clock period 125 ns: low phase 30 + 32.5, high phase 62.5
  localparam realtime T_LOW_A = 30.0;
  localparam realtime T_LOW_B = 32.5;
  localparam realtime T_HIGH = 62.5;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task bit_x(input logic b, output logic r);
    #(T_LOW_A);
    sda_low = !b;
    #(T_LOW_B);
    scl = 1'b1;
    #(T_HIGH);
    r = sda;
    scl = 1'b0;
  endtask
  task start;
    @(posedge clk);
    #1;
    #(T_LOW_A);
    sda_low = 1'b0;
    #(T_LOW_B);
    scl = 1'b1;
    #(T_LOW_A);
    sda_low = 1'b1;
    #(T_LOW_B);
    scl = 1'b0;
  endtask
  task stop;
    #(T_LOW_A);
    sda_low = 1'b1;
    #(T_LOW_B);
    scl = 1'b1;
    #(T_LOW_A);
    sda_low = 1'b0;
    #(T_LOW_B);
  endtask
  task wbyte(input logic [7:0] b, output logic [7:0] ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = {7'h00, !r};
  endtask
  task rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(nack, r);
  endtask
endmodule // iox_master
`default_nettype wire

/* File: test/iox_expander_bench.sv */
// self-checking bench for the i2c io expander
`timescale 1ns/100ps
`default_nettype none
module iox_expander_bench;
  logic clk = 1'b0, rst = 1'b1, rst_n = 1'b1, sa_hi = 1'b1, sa_lo = 1'b0;
  logic scl, sda_low, sdo, sda_oe_n, alert_o, alert_oe_n;
  logic [7:0] ext = 8'h5a, pout, poe_n, pin, ack, d, adr = 8'he4;
  int n_mismatch = 0, checks = 0;
  wire logic sda = !(sda_low || !sda_oe_n);
  assign pin = (poe_n & ext) | (~poe_n & pout);
  always #4 clk = ~clk;
  iox_expander #(.PINS(8)) uut (.CLK_SYS(clk), .RESET(rst), .RESET_N_PIN(rst_n), .SCL_IN(scl),
    .SDA_IN(sda), .SDA_OUT(sdo), .SDA_OE_N(sda_oe_n), .ADDR_SELECT_HI(sa_hi), .ADDR_SELECT_LO(sa_lo),
    .PORT_PIN_IN(pin), .PORT_PIN_OUT(pout), .PORT_PIN_OE_N(poe_n), .ALERT_N_OUT(alert_o),
    .ALERT_N_OE_N(alert_oe_n));
  iox_master m (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  task w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task wr(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1);
    m.start;
    m.wbyte(adr, ack);
    check(ack, 8'h01);
    m.wbyte(p, ack);
    check(ack, 8'h01);
    m.wbyte(d0, ack);
    check(ack, 8'h01);
    m.wbyte(d1, ack);
    check(ack, 8'h01);
    m.stop;
    w(10);
  endtask
  task rd(input logic [7:0] p, input logic [7:0] e, input logic cmd);
    if (cmd) begin
      m.start;
      m.wbyte(adr, ack);
      check(ack, 8'h01);
      m.wbyte(p, ack);
      check(ack, 8'h01);
    end
    m.start;
    m.wbyte(adr | 8'h01, ack);
    check(ack, 8'h01);
    m.rbyte(1'b0, d);
    check(d, e);
    m.rbyte(1'b1, d);
    check(d, e);
    check({7'h00, sda_oe_n}, 8'h01);
    m.stop;
    w(10);
  endtask
  task s_reset;
    check(poe_n, 8'hff);
    check(pout, 8'hff);
    check({6'h00, sdo, alert_o}, 8'h00);
  endtask
  task s_write;
    wr(8'h03, 8'h00, 8'h0f);
    check(poe_n, 8'h0f);
    wr(8'h01, 8'h00, 8'h3c);
    check(pout, 8'h3c);
    wr(8'h00, 8'h11, 8'h22);
    check(poe_n, 8'h0f);
    check(pout, 8'h3c);
  endtask
  task s_read_alert;
    wr(8'h02, 8'h00, 8'hf0);
    rd(8'h00, 8'hca, 1'b1);
    ext = 8'hdb;
    w(20);
    check({7'h00, alert_oe_n}, 8'h00);
    ext = 8'h5a;
    w(20);
    check({7'h00, alert_oe_n}, 8'h01);
    ext = 8'hdb;
    w(20);
    check({7'h00, alert_oe_n}, 8'h00);
    rd(8'h00, 8'hcb, 1'b0);
    check({7'h00, alert_oe_n}, 8'h01);
    ext = 8'h2b;
    w(20);
    check({7'h00, alert_oe_n}, 8'h01);
    rd(8'h01, 8'h3c, 1'b1);
  endtask
  task s_nomatch;
    sa_lo = 1'b1;
    w(20);
    m.start;
    m.wbyte(adr, ack);
    check(ack, 8'h00);
    m.wbyte(8'h03, ack);
    check(ack, 8'h00);
    m.stop;
    w(10);
    check(poe_n, 8'h0f);
    adr = 8'he6;
    wr(8'h03, 8'h00, 8'h55);
    check(poe_n, 8'h55);
  endtask
  task s_pin_reset;
    rst_n = 1'b0;
    w(10);
    rst_n = 1'b1;
    w(20);
    check(poe_n, 8'hff);
    check(pout, 8'hff);
    check({7'h00, alert_oe_n}, 8'h01);
    rd(8'h02, 8'h00, 1'b1);
  endtask
  initial begin
    w(8); rst = 1'b0; w(20);
    s_reset; s_write; s_read_alert; s_nomatch; s_pin_reset;
    conclude;
  end
  initial begin
    w(99000); n_mismatch++;
    conclude;
  end
endmodule // iox_expander_bench
`default_nettype wire
